// ### dv/dct_pin_model.sv
`timescale 1ns/1ps
module dct_pin_model (
  input  wire logic  clk_sys_i,
  output logic [5:0] pins_o
);
  // Bits: count a, b, c, gate a, gate b, trigger; gates start low
  initial pins_o = 6'h27;
  // One falling edge, each level held well past the synchroniser depth
  task automatic pulse(input int idx);
    @(posedge clk_sys_i);
    #1 pins_o[idx] = 1'b0;
    repeat (5) @(posedge clk_sys_i);
    #1 pins_o[idx] = 1'b1;
    repeat (8) @(posedge clk_sys_i);
  endtask
  task automatic level(input int idx, input logic v);
    @(posedge clk_sys_i);
    #1 pins_o[idx] = v;
  endtask
endmodule

// ### dv/dct_timers_sva.sv
`timescale 1ns/1ps
module dct_timers_sva
  import dct_pkg::*;
#(
  parameter int MC_DIV = 2
) (
  input wire logic                  clk_sys_i,
  input wire logic                  rst_n_i,
  input wire dct_pkg::dct_sfr_req_t sfr_i,
  input wire dct_pkg::dct_irq_ack_t irq_ack_i,
  input wire logic                  overflow_flag_a_o,
  input wire logic                  overflow_flag_b_o,
  input wire logic                  overflow_flag_c_o,
  input wire logic                  external_event_flag_o,
  input wire logic                  rx_baud_tick_o,
  input wire logic                  tx_baud_tick_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  // ==========================================================================
  // Shadow of the baud selects, taken from software writes
  logic t2w;
  logic tcw;
  logic baud_reg;
  logic baud_next;
  assign t2w = sfr_i.wr && (sfr_i.addr == ADDR_THIRD_TIMER_CONTROL);
  assign tcw = sfr_i.wr && (sfr_i.addr == ADDR_TIMER_CONTROL_REG);
  always_comb baud_next = !rst_n_i ? 1'b0 : (t2w ? |sfr_i.wdata[5:4] : baud_reg);
  always_ff @(posedge clk_sys_i) baud_reg <= baud_next;
  // ==========================================================================
  // Properties
  flag_c_hold_a: assert property (overflow_flag_c_o && !t2w |=> overflow_flag_c_o)
    else $error("overflow flag c dropped without a write");
  ext_flag_hold_a: assert property (external_event_flag_o && !t2w |=> external_event_flag_o)
    else $error("external flag dropped without a write");
  flag_a_hold_a: assert property (
    overflow_flag_a_o && !tcw && !irq_ack_i.ack_a |=> overflow_flag_a_o)
    else $error("overflow flag a dropped without ack");
  flag_b_hold_a: assert property (
    overflow_flag_b_o && !tcw && !irq_ack_i.ack_b |=> overflow_flag_b_o)
    else $error("overflow flag b dropped without ack");
  baud_no_tf_a: assert property (baud_reg && !t2w |=> !$rose(overflow_flag_c_o))
    else $error("overflow flag c set in baud mode");
  baud_no_ext_a: assert property (baud_reg && !t2w |=> !$rose(external_event_flag_o))
    else $error("trigger acted in baud mode");
  rx_tick_pulse_a: assert property (rx_baud_tick_o |=> !rx_baud_tick_o)
    else $error("rx tick longer than one cycle");
  tx_tick_pulse_a: assert property (tx_baud_tick_o |=> !tx_baud_tick_o)
    else $error("tx tick longer than one cycle");
  cover property (overflow_flag_c_o);
  cover property (external_event_flag_o);
  cover property (tx_baud_tick_o && baud_reg);
endmodule

// ### dv/test_dct_timers.sv
`timescale 1ns/1ps
module test_dct_timers;
  import dct_pkg::*;
  logic         clk_sys_i = 1'b0;
  logic         rst_n_i = 1'b0;
  dct_sfr_req_t sfr = '0;
  dct_irq_ack_t ack = '0;
  logic [5:0]   pins;
  logic [7:0]   rdata;
  logic [5:0]   outs;
  logic [7:0]   d;
  int           num_errors = 0;
  int           cmp_count = 0;
  always #2.5 clk_sys_i = ~clk_sys_i;
  dct_pin_model u_dct_pin_model (.clk_sys_i(clk_sys_i), .pins_o(pins));
  dct_timers #(.MC_DIV(2)) u_dct_timers (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .sfr_i(sfr), .irq_ack_i(ack), .count_pin_a_i(pins[0]), .count_pin_b_i(pins[1]),
    .count_pin_c_i(pins[2]), .ext_interrupt_pin_a_i(pins[3]),
    .ext_interrupt_pin_b_i(pins[4]), .external_trigger_pin_i(pins[5]),
    .sfr_rdata_o(rdata), .overflow_flag_a_o(outs[0]), .overflow_flag_b_o(outs[1]),
    .overflow_flag_c_o(outs[2]), .external_event_flag_o(outs[3]),
    .rx_baud_tick_o(outs[4]), .tx_baud_tick_o(outs[5]));
  // ==========================================================================
  // Shared tasks
  task automatic end_sim();
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_sys_i);
    #1 sfr = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(posedge clk_sys_i);
    #1 sfr = '0;
  endtask
  task automatic rchk(input string nm, input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys_i);
    #1 sfr = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk_sys_i);
    #1 sfr = '0;
    d = rdata;
    chk(nm, exp, d);
  endtask
  task automatic wait_hi(input int idx);
    for (int i = 0; i < 400; i++) begin
      @(posedge clk_sys_i);
      #1;
      if (outs[idx] === 1'b1) return;
    end
    num_errors++;
    $display("[ERR] output %0d expected 1 seen 0", idx);
    end_sim();
  endtask
  // ==========================================================================
  // Scenarios
  task automatic t_reset();
    chk("flags", 8'h00, {2'b00, outs});
    rchk("third_timer_control", ADDR_THIRD_TIMER_CONTROL, 8'h00);
    rchk("tlb", ADDR_TLB, 8'h00);
    rchk("unmapped", 8'h00, 8'h00);
  endtask
  task automatic t_mode0();
    wr(ADDR_TIMER_MODE_REG, 8'h04);
    wr(ADDR_TLA, 8'h1f);
    wr(ADDR_THA, 8'hff);
    wr(ADDR_TIMER_CONTROL_REG, 8'h10);
    rchk("tha_run", ADDR_THA, 8'hff);
    u_dct_pin_model.pulse(0);
    wait_hi(0);
    rchk("tla_low5", ADDR_TLA, 8'h00);
    rchk("tha_wrap", ADDR_THA, 8'h00);
    @(posedge clk_sys_i);
    #1 ack.ack_a = 1'b1;
    @(posedge clk_sys_i);
    #1 ack.ack_a = 1'b0;
    @(posedge clk_sys_i);
    #1 chk("flag_a", 8'h00, {7'h0, outs[0]});
  endtask
  task automatic t_gate();
    wr(ADDR_TIMER_MODE_REG, 8'h0d);
    wr(ADDR_TLA, 8'h10);
    u_dct_pin_model.pulse(0);
    rchk("tla_gated", ADDR_TLA, 8'h10);
    u_dct_pin_model.level(3, 1'b1);
    u_dct_pin_model.pulse(0);
    rchk("tla_open", ADDR_TLA, 8'h11);
    wr(ADDR_TLA, 8'hff);
    u_dct_pin_model.pulse(0);
    rchk("tha_carry", ADDR_THA, 8'h01);
  endtask
  task automatic t_reload_b();
    wr(ADDR_TIMER_MODE_REG, 8'h20);
    wr(ADDR_THB, 8'hf0);
    wr(ADDR_TLB, 8'hfe);
    wr(ADDR_TIMER_CONTROL_REG, 8'h40);
    wait_hi(1);
    rchk("thb_kept", ADDR_THB, 8'hf0);
    wait_hi(4);
    wait_hi(5);
    wr(ADDR_TIMER_CONTROL_REG, 8'h00);
  endtask
  task automatic t_count_b();
    @(posedge clk_sys_i);
    #1 ack.ack_b = 1'b1;
    @(posedge clk_sys_i);
    #1 ack.ack_b = 1'b0;
    @(posedge clk_sys_i);
    #1 chk("flag_b", 8'h00, {7'h0, outs[1]});
    wr(ADDR_TIMER_MODE_REG, 8'hd0);
    wr(ADDR_TLB, 8'hff);
    wr(ADDR_THB, 8'hff);
    wr(ADDR_TIMER_CONTROL_REG, 8'h40);
    u_dct_pin_model.pulse(1);
    rchk("tlb_gated", ADDR_TLB, 8'hff);
    u_dct_pin_model.level(4, 1'b1);
    u_dct_pin_model.pulse(1);
    wait_hi(1);
    rchk("tlb_wrap", ADDR_TLB, 8'h00);
    rchk("thb_wrap", ADDR_THB, 8'h00);
    wr(ADDR_TIMER_CONTROL_REG, 8'h00);
  endtask
  task automatic t_capture();
    wr(ADDR_TLC, 8'h34);
    wr(ADDR_THC, 8'h12);
    wr(ADDR_THIRD_TIMER_CONTROL, 8'h0f);
    u_dct_pin_model.pulse(5);
    wait_hi(3);
    rchk("rcapl", ADDR_RCAPL, 8'h34);
    rchk("rcaph", ADDR_RCAPH, 8'h12);
    rchk("third_timer_control_exf", ADDR_THIRD_TIMER_CONTROL, 8'h4f);
    u_dct_pin_model.pulse(2);
    rchk("tlc_count", ADDR_TLC, 8'h35);
    wr(ADDR_THIRD_TIMER_CONTROL, 8'h0f);
    rchk("third_timer_control_clr", ADDR_THIRD_TIMER_CONTROL, 8'h0f);
  endtask
  task automatic t_reload_c();
    wr(ADDR_TLC, 8'h00);
    wr(ADDR_THIRD_TIMER_CONTROL, 8'h0e);
    u_dct_pin_model.pulse(5);
    wait_hi(3);
    rchk("tlc_trig", ADDR_TLC, 8'h34);
    rchk("thc_trig", ADDR_THC, 8'h12);
    wr(ADDR_THIRD_TIMER_CONTROL, 8'h06);
    wr(ADDR_TLC, 8'h00);
    u_dct_pin_model.pulse(5);
    rchk("tlc_noexen", ADDR_TLC, 8'h00);
    wr(ADDR_TLC, 8'hff);
    wr(ADDR_THC, 8'hff);
    u_dct_pin_model.pulse(2);
    rchk("tlc_roll", ADDR_TLC, 8'h34);
    rchk("third_timer_control_tf", ADDR_THIRD_TIMER_CONTROL, 8'h86);
  endtask
  task automatic t_baud();
    wr(ADDR_RCAPL, 8'hfe);
    wr(ADDR_RCAPH, 8'hff);
    wr(ADDR_TLC, 8'hfe);
    wr(ADDR_THC, 8'hff);
    wr(ADDR_THIRD_TIMER_CONTROL, 8'h3d);
    wait_hi(5);
    wait_hi(4);
    u_dct_pin_model.pulse(5);
    chk("baud_flags", 8'h00, {6'h0, outs[3:2]});
    rchk("third_timer_control_baud", ADDR_THIRD_TIMER_CONTROL, 8'h3d);
  endtask
  initial begin
    repeat (12) @(posedge clk_sys_i);
    #1 rst_n_i = 1'b1;
    t_reset();
    t_mode0();
    t_gate();
    t_reload_b();
    t_count_b();
    t_capture();
    t_reload_c();
    t_baud();
    end_sim();
  end
endmodule
bind dct_timers dct_timers_sva #(.MC_DIV(MC_DIV)) u_dct_timers_sva (.clk_sys_i(clk_sys_i),
  .rst_n_i(rst_n_i), .sfr_i(sfr_i), .irq_ack_i(irq_ack_i),
  .overflow_flag_a_o(overflow_flag_a_o), .overflow_flag_b_o(overflow_flag_b_o),
  .overflow_flag_c_o(overflow_flag_c_o), .external_event_flag_o(external_event_flag_o),
  .rx_baud_tick_o(rx_baud_tick_o), .tx_baud_tick_o(tx_baud_tick_o));

// ### pkg/dct_pkg.sv
package dct_pkg;
  // ==========================================================================
  // Register addresses
  localparam logic [7:0] ADDR_TIMER_CONTROL_REG   = 8'h88;
  localparam logic [7:0] ADDR_TIMER_MODE_REG   = 8'h89;
  localparam logic [7:0] ADDR_TLA    = 8'h8a;
  localparam logic [7:0] ADDR_TLB    = 8'h8b;
  localparam logic [7:0] ADDR_THA    = 8'h8c;
  localparam logic [7:0] ADDR_THB    = 8'h8d;
  localparam logic [7:0] ADDR_THIRD_TIMER_CONTROL  = 8'hc8;
  localparam logic [7:0] ADDR_RCAPL  = 8'hca;
  localparam logic [7:0] ADDR_RCAPH  = 8'hcb;
  localparam logic [7:0] ADDR_TLC    = 8'hcc;
  localparam logic [7:0] ADDR_THC    = 8'hcd;
  // ==========================================================================
  // Field positions
  localparam int TIMER_CONTROL_REG_TFB  = 7;
  localparam int TIMER_CONTROL_REG_TRB  = 6;
  localparam int TIMER_CONTROL_REG_TFA  = 5;
  localparam int TIMER_CONTROL_REG_TRA  = 4;
  localparam int TIMER_MODE_REG_GATE = 3;
  localparam int TIMER_MODE_REG_CT   = 2;
  localparam int T2_TF     = 7;
  localparam int T2_EXF    = 6;
  localparam int T2_RCLK   = 5;
  localparam int T2_TX_CLOCK_SELECT   = 4;
  localparam int T2_EXEN   = 3;
  localparam int T2_TR     = 2;
  localparam int T2_CNT    = 1;
  localparam int T2_CAP    = 0;
  // ==========================================================================
  // Reset values and timing
  localparam logic [7:0] RST_BYTE      = 8'h00;
  localparam int         MACHINE_CYCLE = 12;
  localparam int         PRESCALE_DIV  = 32;

  typedef enum logic [1:0] {
    DCT_MODE_13BIT  = 2'b00,
    DCT_MODE_16BIT  = 2'b01,
    DCT_MODE_RELOAD = 2'b10,
    DCT_MODE_SPLIT  = 2'b11
  } dct_mode_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } dct_sfr_req_t;

  typedef struct packed {
    logic ack_a;
    logic ack_b;
  } dct_irq_ack_t;
endpackage

// ### rtl/dct_timers.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Mode 0 count uses divide-by-32 prescaler
// - Mode 0: 13 bits, low byte top ignored
// - Wrap to zero sets overflow flag
// - Count only when run and (ungated or pin high)
// - Setting run bit keeps count registers
// - Mode 1 is full 16-bit counter
// - Mode 2 low byte reloads from high
// - Timer B mode 3 holds its count
// - Timer A mode 3 splits; high uses B controls
// - Timer B still runs out of mode 3
// - Timer C mode from run, clock, capture bits
// - Auto-reload: rollover reloads from reload pair
// - Trigger falling edge also reloads, sets flag
// - Capture mode: 16-bit, overflow sets flag
// - Trigger falling edge captures count, sets flag
// - Baud mode never sets overflow flag C
// - Hardware sets flags C; software clears them
// - Receive baud tick source chosen by bit 5
// - Transmit baud tick source chosen by bit 4
// - Trigger edges ignored unless enabled, non-baud
// - Bit 2 runs timer C; bit 1 picks pin
// - Baud mode forces auto-reload
// - Counter-select picks pin or internal clock
// - Flags A/B cleared on interrupt vector
// - Mode field selects four timer modes
// - Gate bit ties counting to interrupt pin
module dct_timers
  import dct_pkg::*;
#(
  parameter int MC_DIV = MACHINE_CYCLE
) (
  input  wire logic           clk_sys_i,
  input  wire logic           rst_n_i,
  input  wire dct_pkg::dct_sfr_req_t sfr_i,
  input  wire dct_pkg::dct_irq_ack_t irq_ack_i,
  input  wire logic           count_pin_a_i,
  input  wire logic           count_pin_b_i,
  input  wire logic           count_pin_c_i,
  input  wire logic           ext_interrupt_pin_a_i,
  input  wire logic           ext_interrupt_pin_b_i,
  input  wire logic           external_trigger_pin_i,
  output logic [7:0]          sfr_rdata_o,
  output logic                overflow_flag_a_o,
  output logic                overflow_flag_b_o,
  output logic                overflow_flag_c_o,
  output logic                external_event_flag_o,
  output logic                rx_baud_tick_o,
  output logic                tx_baud_tick_o
);
  import dct_pkg::*;

  initial begin
    if (MC_DIV < 1 || MC_DIV > 255) begin
      $error("MC_DIV out of range");
    end
  end

  // ==========================================================================
  // Pin synchronisers: three stages, change accepted when stages 2 and 3 agree
  logic [5:0] s1_reg, s2_reg, s3_reg, lvl_reg;
  logic [5:0] s1_next, s2_next, s3_next, lvl_next;
  logic [5:0] fall;

  always_comb begin
    s1_next  = {external_trigger_pin_i, ext_interrupt_pin_b_i, ext_interrupt_pin_a_i,
                count_pin_c_i, count_pin_b_i, count_pin_a_i};
    s2_next  = s1_reg;
    s3_next  = s2_reg;
    lvl_next = lvl_reg;
    for (int i = 0; i < 6; i++) begin
      if (s2_reg[i] == s3_reg[i]) begin
        lvl_next[i] = s3_reg[i];
      end
    end
    fall = lvl_reg & ~lvl_next;
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      s1_reg  <= 6'h3f;
      s2_reg  <= 6'h3f;
      s3_reg  <= 6'h3f;
      lvl_reg <= 6'h3f;
    end else begin
      s1_reg  <= s1_next;
      s2_reg  <= s2_next;
      s3_reg  <= s3_next;
      lvl_reg <= lvl_next;
    end
  end

  // ==========================================================================
  // Machine-cycle enable
  logic [7:0] mc_cnt_reg, mc_cnt_next;
  logic       mc_tick;

  always_comb begin
    mc_tick     = (mc_cnt_reg == 8'(MC_DIV - 1));
    mc_cnt_next = mc_tick ? 8'h00 : mc_cnt_reg + 8'h01;
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      mc_cnt_reg <= 8'h00;
    end else begin
      mc_cnt_reg <= mc_cnt_next;
    end
  end

  // ==========================================================================
  // Register state and counting
  logic [7:0] timer_control_reg_reg, timer_mode_reg_reg, third_timer_control_reg;
  logic [7:0] tla_reg, tha_reg, tlb_reg, thb_reg, tlc_reg, thc_reg, rcl_reg, rch_reg;
  logic [7:0] timer_control_reg_next, timer_mode_reg_next, third_timer_control_next;
  logic [7:0] tla_next, tha_next, tlb_next, thb_next, tlc_next, thc_next;
  logic [7:0] rcl_next, rch_next;
  logic [7:0] rdata_next;
  logic       rx_next, tx_next;

  // One timer step for modes 0..2; returns {overflow, high, low}
  function automatic logic [16:0] step(input logic [1:0] mode,
                                       input logic [7:0] hi,
                                       input logic [7:0] lo);
    logic [16:0] r;
    r = {1'b0, hi, lo};
    case (mode)
      DCT_MODE_13BIT: begin
        if (lo[4:0] == 5'h1f) begin
          r = {hi == 8'hff, hi + 8'h01, lo[7:5], 5'h00};
        end else begin
          r = {1'b0, hi, lo[7:5], lo[4:0] + 5'h01};
        end
      end
      DCT_MODE_16BIT: begin
        r = {({hi, lo} == 16'hffff), hi, lo} + 17'h00001;
        r[16] = ({hi, lo} == 16'hffff);
      end
      DCT_MODE_RELOAD: begin
        r = (lo == 8'hff) ? {1'b1, hi, hi} : {1'b0, hi, lo + 8'h01};
      end
      default: r = {1'b0, hi, lo};
    endcase
    return r;
  endfunction

  logic        en_a, en_b, en_c, ev_a, ev_b, ev_c, ev_ha;
  logic        split_a, baud, cnt_c, trig;
  logic [1:0]  mode_a, mode_b;
  logic [16:0] ra, rb;
  logic [16:0] rc;

  always_comb begin
    mode_a  = timer_mode_reg_reg[1:0];
    mode_b  = timer_mode_reg_reg[5:4];
    split_a = (mode_a == DCT_MODE_SPLIT);
    en_a = timer_control_reg_reg[TIMER_CONTROL_REG_TRA] && (!timer_mode_reg_reg[TIMER_MODE_REG_GATE] || lvl_reg[3]);
    en_b = timer_control_reg_reg[TIMER_CONTROL_REG_TRB] && (!timer_mode_reg_reg[TIMER_MODE_REG_GATE + 4] || lvl_reg[4])
           && (mode_b != DCT_MODE_SPLIT);
    ev_a  = en_a && (timer_mode_reg_reg[TIMER_MODE_REG_CT] ? fall[0] : mc_tick);
    ev_b  = en_b && (timer_mode_reg_reg[TIMER_MODE_REG_CT + 4] ? fall[1] : mc_tick);
    ev_ha = split_a && timer_control_reg_reg[TIMER_CONTROL_REG_TRB] && mc_tick;
    baud  = third_timer_control_reg[T2_RCLK] || third_timer_control_reg[T2_TX_CLOCK_SELECT];
    cnt_c = third_timer_control_reg[T2_CNT] ? fall[2] : mc_tick;
    en_c  = third_timer_control_reg[T2_TR];
    ev_c  = en_c && cnt_c;
    trig  = fall[5] && third_timer_control_reg[T2_EXEN] && !baud;

    timer_control_reg_next  = timer_control_reg_reg;
    timer_mode_reg_next  = timer_mode_reg_reg;
    third_timer_control_next = third_timer_control_reg;
    tla_next = tla_reg;
    tha_next = tha_reg;
    tlb_next = tlb_reg;
    thb_next = thb_reg;
    tlc_next = tlc_reg;
    thc_next = thc_reg;
    rcl_next = rcl_reg;
    rch_next = rch_reg;
    rx_next  = 1'b0;
    tx_next  = 1'b0;
    ra = 17'h00000;
    rb = 17'h00000;
    rc = 17'h00000;

    // Software writes first; hardware flag sets below override clears
    if (sfr_i.wr) begin
      case (sfr_i.addr)
        ADDR_TIMER_CONTROL_REG:  timer_control_reg_next = sfr_i.wdata;
        ADDR_TIMER_MODE_REG:  timer_mode_reg_next = sfr_i.wdata;
        ADDR_TLA:   tla_next = sfr_i.wdata;
        ADDR_THA:   tha_next = sfr_i.wdata;
        ADDR_TLB:   tlb_next = sfr_i.wdata;
        ADDR_THB:   thb_next = sfr_i.wdata;
        ADDR_THIRD_TIMER_CONTROL: third_timer_control_next = sfr_i.wdata;
        ADDR_RCAPL: rcl_next = sfr_i.wdata;
        ADDR_RCAPH: rch_next = sfr_i.wdata;
        ADDR_TLC:   tlc_next = sfr_i.wdata;
        ADDR_THC:   thc_next = sfr_i.wdata;
        default: ;
      endcase
    end
    if (irq_ack_i.ack_a) begin
      timer_control_reg_next[TIMER_CONTROL_REG_TFA] = 1'b0;
    end
    if (irq_ack_i.ack_b) begin
      timer_control_reg_next[TIMER_CONTROL_REG_TFB] = 1'b0;
    end

    // Timer A
    if (ev_a) begin
      if (split_a) begin
        ra = {tla_reg == 8'hff, tha_reg, tla_reg + 8'h01};
      end else begin
        ra = step(mode_a, tha_reg, tla_reg);
        tha_next = ra[15:8];
      end
      tla_next = ra[7:0];
      if (ra[16]) begin
        timer_control_reg_next[TIMER_CONTROL_REG_TFA] = 1'b1;
      end
    end
    if (ev_ha) begin
      tha_next = tha_reg + 8'h01;
      if (tha_reg == 8'hff) begin
        timer_control_reg_next[TIMER_CONTROL_REG_TFB] = 1'b1;
      end
    end

    // Timer B; its overflow still feeds the baud path in split mode
    if (ev_b) begin
      rb = step(mode_b, thb_reg, tlb_reg);
      tlb_next = rb[7:0];
      thb_next = rb[15:8];
      if (rb[16] && !split_a) begin
        timer_control_reg_next[TIMER_CONTROL_REG_TFB] = 1'b1;
      end
    end

    // Timer C
    if (ev_c) begin
      rc = {1'b0, thc_reg, tlc_reg} + 17'h00001;
      if (rc[16] && (baud || !third_timer_control_reg[T2_CAP])) begin
        rc[15:0] = {rch_reg, rcl_reg};
      end
      tlc_next = rc[7:0];
      thc_next = rc[15:8];
      if (rc[16] && !baud) begin
        third_timer_control_next[T2_TF] = 1'b1;
      end
    end
    if (trig) begin
      third_timer_control_next[T2_EXF] = 1'b1;
      if (third_timer_control_reg[T2_CAP]) begin
        rcl_next = tlc_reg;
        rch_next = thc_reg;
      end else begin
        tlc_next = rcl_reg;
        thc_next = rch_reg;
      end
    end

    // Baud ticks
    rx_next = third_timer_control_reg[T2_RCLK] ? (ev_c && rc[16]) : (ev_b && rb[16]);
    tx_next = third_timer_control_reg[T2_TX_CLOCK_SELECT] ? (ev_c && rc[16]) : (ev_b && rb[16]);

    case (sfr_i.addr)
      ADDR_TIMER_CONTROL_REG:  rdata_next = timer_control_reg_reg;
      ADDR_TIMER_MODE_REG:  rdata_next = timer_mode_reg_reg;
      ADDR_TLA:   rdata_next = tla_reg;
      ADDR_THA:   rdata_next = tha_reg;
      ADDR_TLB:   rdata_next = tlb_reg;
      ADDR_THB:   rdata_next = thb_reg;
      ADDR_THIRD_TIMER_CONTROL: rdata_next = third_timer_control_reg;
      ADDR_RCAPL: rdata_next = rcl_reg;
      ADDR_RCAPH: rdata_next = rch_reg;
      ADDR_TLC:   rdata_next = tlc_reg;
      ADDR_THC:   rdata_next = thc_reg;
      default:    rdata_next = RST_BYTE;
    endcase
    if (!sfr_i.rd) begin
      rdata_next = sfr_rdata_o;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      timer_control_reg_reg    <= RST_BYTE;
      timer_mode_reg_reg    <= RST_BYTE;
      third_timer_control_reg   <= RST_BYTE;
      tla_reg     <= RST_BYTE;
      tha_reg     <= RST_BYTE;
      tlb_reg     <= RST_BYTE;
      thb_reg     <= RST_BYTE;
      tlc_reg     <= RST_BYTE;
      thc_reg     <= RST_BYTE;
      rcl_reg     <= RST_BYTE;
      rch_reg     <= RST_BYTE;
      sfr_rdata_o <= RST_BYTE;
      rx_baud_tick_o <= 1'b0;
      tx_baud_tick_o <= 1'b0;
    end else begin
      timer_control_reg_reg    <= timer_control_reg_next;
      timer_mode_reg_reg    <= timer_mode_reg_next;
      third_timer_control_reg   <= third_timer_control_next;
      tla_reg     <= tla_next;
      tha_reg     <= tha_next;
      tlb_reg     <= tlb_next;
      thb_reg     <= thb_next;
      tlc_reg     <= tlc_next;
      thc_reg     <= thc_next;
      rcl_reg     <= rcl_next;
      rch_reg     <= rch_next;
      sfr_rdata_o <= rdata_next;
      rx_baud_tick_o <= rx_next;
      tx_baud_tick_o <= tx_next;
    end
  end

  // Flags shown straight from register bits
  assign overflow_flag_a_o     = timer_control_reg_reg[TIMER_CONTROL_REG_TFA];
  assign overflow_flag_b_o     = timer_control_reg_reg[TIMER_CONTROL_REG_TFB];
  assign overflow_flag_c_o     = third_timer_control_reg[T2_TF];
  assign external_event_flag_o = third_timer_control_reg[T2_EXF];
endmodule
